// ---- remote_host_access_arbiter_consts.vh ----
`ifndef REMOTE_HOST_ACCESS_ARBITER_CONSTS_VH
`define REMOTE_HOST_ACCESS_ARBITER_CONSTS_VH

// Register indices on the software port
`define ADDR_RIC          4'h0
`define ADDR_CCR          4'h1
`define ADDR_DCR          4'h2
`define ADDR_PC_LO        4'h3
`define ADDR_PC_HI        4'h4

// remote_interface_config fields
`define RIC_RUN_BIT       0
`define RIC_STEP_BIT      1
`define RIC_LOCKOUT_BIT   2
`define RIC_MSEL_LSB      3
`define RIC_MSEL_MSB      4

// cpu_control_reg fields
`define CCR_WRITE_SEEN    6
`define CCR_READ_SEEN     5

// device_config_reg fields
`define DCR_IW_LSB        0
`define DCR_IW_MSB        1
`define DCR_DW_LSB        2
`define DCR_DW_MSB        4

// Memory select encodings
`define MSEL_DATA_MEMORY         2'h0
`define MSEL_INSTRUCTION_MEMORY         2'h1
`define MSEL_PC_LO        2'h2
`define MSEL_PC_HI        2'h3

// Access targets held during the access phase
`define TGT_CFG           3'h0
`define TGT_PC_LO         3'h1
`define TGT_PC_HI         3'h2
`define TGT_DATA_MEMORY          3'h3
`define TGT_INSTRUCTION_MEMORY_LO       3'h4
`define TGT_INSTRUCTION_MEMORY_HI       3'h5

// Reset values
`define RIC_RESET         8'h00
`define DCR_RESET         8'h00
`define PC_RESET          16'h0000
`define WAIT_ZERO         3'h0

`endif

// ---- remote_host_access_arbiter.v ----
// Local design decisions: the register addresses and the plain strobed port.
`include "remote_host_access_arbiter_consts.vh"

module remote_host_access_arbiter #(
   parameter IW_WIDTH = 2,
   parameter DW_WIDTH = 3
) (
   input  wire        core_clk_i,
   input  wire        sys_rst_i,
   input  wire [3:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [7:0]  reg_rdata_o,
   input  wire        remote_read_strobe_n_i,
   input  wire        remote_write_strobe_n_i,
   input  wire        remote_access_enable_i,
   input  wire        reg_select_i,
   input  wire        access_stretch_n_i,
   input  wire        local_block_n_i,
   input  wire        local_bus_request_i,
   input  wire        instr_start_i,
   input  wire        instr_done_i,
   input  wire [7:0]  data_addr_hi_i,
   input  wire [15:0] instr_data_i,
   output reg         local_bus_grant_o,
   output reg         timing_unit_stall_o,
   output reg         transfer_ack_pin_o,
   output reg         bus_handover_pin_o,
   output reg         mem_read_n_o,
   output reg  [7:0]  addr_hi_o,
   output reg         addr_hi_oe_n_o,
   output reg  [7:0]  ad_o,
   output reg         ad_oe_n_o,
   output reg         cpu_running_o,
   output reg  [15:0] pc_o
);

   localparam [3:0] IDLE_STATE     = 4'h0;
   localparam [3:0] HELD_OFF_STATE = 4'h1;
   localparam [3:0] BUS_RELEASE    = 4'h2;
   localparam [3:0] HANDOVER_STATE = 4'h3;
   localparam [3:0] ACCESS_STATE   = 4'h4;
   localparam [3:0] DATA_VALID     = 4'h5;
   localparam [3:0] TERM_STATE     = 4'h6;

   // Two-stage synchronisers for pins
   reg [5:0]  pin_meta_reg;
   reg [5:0]  pin_sync_reg;
   wire       rd_n_s    = pin_sync_reg[0];
   wire       wr_n_s    = pin_sync_reg[1];
   wire       rae_s     = pin_sync_reg[2];
   wire       cmd_s     = pin_sync_reg[3];
   wire       stretch_s = pin_sync_reg[4];
   wire       lock_n_s  = pin_sync_reg[5];

   reg [7:0]           ric_reg;
   reg [7:0]           dcr_reg;
   reg                 write_seen_reg;
   reg                 read_seen_reg;
   reg [15:0]          pc_reg;
   reg                 upper_byte_flag_reg;
   reg                 step_reg;
   reg                 running_reg;
   reg                 strap_done_reg;
   reg                 lock_active_reg;
   reg [3:0]           state_reg;
   reg [3:0]           state_next;
   reg [2:0]           target_reg;
   reg [2:0]           target_next;
   reg [IW_WIDTH-1:0]  iw_cnt_reg;
   reg [DW_WIDTH-1:0]  dw_cnt_reg;

   wire qualified_rd  = rae_s & ~rd_n_s;
   wire lockout       = ric_reg[`RIC_LOCKOUT_BIT];
   wire [1:0] msel    = ric_reg[`RIC_MSEL_MSB:`RIC_MSEL_LSB];
   wire wr_ric        = reg_wr_i && (reg_addr_i == `ADDR_RIC);
   wire in_arb        = (state_reg == IDLE_STATE) || (state_reg == HELD_OFF_STATE);
   wire instruction_memory_target   = (target_reg == `TGT_INSTRUCTION_MEMORY_LO) || (target_reg == `TGT_INSTRUCTION_MEMORY_HI);
   wire waits_spent;

   // Wait count still running for the current target
   function wait_pending;
      input [2:0]          tgt;
      input [IW_WIDTH-1:0] iw;
      input [DW_WIDTH-1:0] dw;
      begin
         if (tgt == `TGT_DATA_MEMORY) begin
            wait_pending = (dw != {DW_WIDTH{1'b0}});
         end else if ((tgt == `TGT_INSTRUCTION_MEMORY_LO) || (tgt == `TGT_INSTRUCTION_MEMORY_HI)) begin
            wait_pending = (iw != {IW_WIDTH{1'b0}});
         end else begin
            wait_pending = 1'b0;
         end
      end
   endfunction

   assign waits_spent = ~wait_pending(target_reg, iw_cnt_reg, dw_cnt_reg) & stretch_s;

   // Pin synchronisers, kept running through reset so the strap sees the strobes
   always @(posedge core_clk_i) begin
      pin_meta_reg <= {local_block_n_i, access_stretch_n_i, reg_select_i,
                       remote_access_enable_i, remote_write_strobe_n_i, remote_read_strobe_n_i};
      pin_sync_reg <= pin_meta_reg;
   end

   // Arbiter next state
   always @* begin
      state_next  = state_reg;
      target_next = target_reg;
      case (state_reg)
         IDLE_STATE: begin
            if (qualified_rd) begin
               if (lockout || local_bus_grant_o) begin
                  state_next = HELD_OFF_STATE;
               end else if (!local_bus_request_i) begin
                  state_next = BUS_RELEASE;
               end
            end
         end
         HELD_OFF_STATE: begin
            if (!qualified_rd) begin
               state_next = IDLE_STATE;
            end else if (!lockout && !local_bus_grant_o && !local_bus_request_i) begin
               state_next = BUS_RELEASE;
            end
         end
         BUS_RELEASE: state_next = HANDOVER_STATE;
         HANDOVER_STATE: begin
            state_next = ACCESS_STATE;
            if (cmd_s) begin
               target_next = `TGT_CFG;
            end else begin
               case (msel)
                  `MSEL_DATA_MEMORY:  target_next = `TGT_DATA_MEMORY;
                  `MSEL_PC_LO: target_next = `TGT_PC_LO;
                  `MSEL_PC_HI: target_next = `TGT_PC_HI;
                  default:     target_next = upper_byte_flag_reg ? `TGT_INSTRUCTION_MEMORY_HI : `TGT_INSTRUCTION_MEMORY_LO;
               endcase
            end
         end
         ACCESS_STATE: begin
            if (waits_spent) begin
               state_next = DATA_VALID;
            end
         end
         DATA_VALID: begin
            if (!qualified_rd) begin
               state_next = TERM_STATE;
            end
         end
         TERM_STATE: state_next = IDLE_STATE;
         default: state_next = IDLE_STATE;
      endcase
   end

   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg  <= IDLE_STATE;
         target_reg <= `TGT_CFG;
      end else begin
         state_reg  <= state_next;
         target_reg <= target_next;
      end
   end

   // Wait counters
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         iw_cnt_reg <= {IW_WIDTH{1'b0}};
         dw_cnt_reg <= {DW_WIDTH{1'b0}};
      end else if (state_reg == HANDOVER_STATE) begin
         iw_cnt_reg <= dcr_reg[`DCR_IW_MSB:`DCR_IW_LSB];
         dw_cnt_reg <= dcr_reg[`DCR_DW_MSB:`DCR_DW_LSB];
      end else if (state_reg == ACCESS_STATE) begin
         if ((target_reg == `TGT_DATA_MEMORY) && (dw_cnt_reg != {DW_WIDTH{1'b0}})) begin
            dw_cnt_reg <= dw_cnt_reg - {{(DW_WIDTH-1){1'b0}}, 1'b1};
         end
         if (instruction_memory_target && (iw_cnt_reg != {IW_WIDTH{1'b0}})) begin
            iw_cnt_reg <= iw_cnt_reg - {{(IW_WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // Pin outputs of the arbiter
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         local_bus_grant_o   <= 1'b0;
         timing_unit_stall_o <= 1'b0;
         transfer_ack_pin_o  <= 1'b1;
         bus_handover_pin_o  <= 1'b0;
         mem_read_n_o        <= 1'b1;
         addr_hi_o           <= 8'h00;
         addr_hi_oe_n_o      <= 1'b0;
         ad_o                <= `RIC_RESET;
         ad_oe_n_o           <= 1'b0;
      end else begin
         local_bus_grant_o <= (state_next == IDLE_STATE || state_next == HELD_OFF_STATE)
                              && in_arb && lock_n_s && local_bus_request_i;
         // stall while the local bus is requested, on block or remote ownership
         timing_unit_stall_o <= local_bus_request_i && (lock_active_reg || !in_arb
                                || (state_next != IDLE_STATE && state_next != HELD_OFF_STATE));
         transfer_ack_pin_o <= !(qualified_rd && state_next != DATA_VALID && state_next != TERM_STATE);
         bus_handover_pin_o <= (state_next == HANDOVER_STATE) || (state_next == ACCESS_STATE)
                               || (state_next == DATA_VALID);
         mem_read_n_o <= !((state_next == ACCESS_STATE || state_next == DATA_VALID)
                           && target_next == `TGT_DATA_MEMORY);
         addr_hi_o <= data_addr_hi_i;
         ad_o      <= ric_reg & ~(8'h01 << `RIC_STEP_BIT);
         addr_hi_oe_n_o <= !(state_next == IDLE_STATE || state_next == HELD_OFF_STATE
                             || state_next == TERM_STATE);
         ad_oe_n_o <= 1'b0;
         if (state_next == BUS_RELEASE || state_next == HANDOVER_STATE) begin
            ad_oe_n_o <= (msel == `MSEL_DATA_MEMORY) && !cmd_s;
         end else if (state_next == ACCESS_STATE || state_next == DATA_VALID) begin
            case (target_next)
               `TGT_PC_LO:   ad_o <= pc_reg[7:0];
               `TGT_PC_HI:   ad_o <= pc_reg[15:8];
               `TGT_INSTRUCTION_MEMORY_LO: ad_o <= instr_data_i[7:0];
               `TGT_INSTRUCTION_MEMORY_HI: ad_o <= instr_data_i[15:8];
               `TGT_DATA_MEMORY:    ad_oe_n_o <= 1'b1;
               default:      ad_o <= ric_reg & ~(8'h01 << `RIC_STEP_BIT);
            endcase
         end
      end
   end

   // Local block sampled at instruction start
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lock_active_reg <= 1'b0;
      end else if (instr_start_i) begin
         lock_active_reg <= ~lock_n_s;
      end
   end

   // Software registers, flags and execution control
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ric_reg             <= `RIC_RESET;
         dcr_reg             <= `DCR_RESET;
         write_seen_reg      <= 1'b0;
         read_seen_reg       <= 1'b0;
         pc_reg              <= `PC_RESET;
         upper_byte_flag_reg <= 1'b0;
         step_reg            <= 1'b0;
         running_reg         <= 1'b0;
         strap_done_reg      <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
         if (!strap_done_reg && !rd_n_s && !wr_n_s) begin
            ric_reg[`RIC_RUN_BIT] <= 1'b1;
            pc_reg                <= `PC_RESET;
         end
         if (wr_ric) begin
            ric_reg <= reg_wdata_i & ~(8'h01 << `RIC_STEP_BIT);
            if (reg_wdata_i[`RIC_STEP_BIT]) step_reg <= 1'b1;
            if (reg_wdata_i[`RIC_MSEL_MSB:`RIC_MSEL_LSB] == `MSEL_INSTRUCTION_MEMORY) upper_byte_flag_reg <= 1'b0;
         end
         if (reg_wr_i && reg_addr_i == `ADDR_DCR) dcr_reg <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `ADDR_PC_LO) pc_reg[7:0] <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `ADDR_PC_HI) pc_reg[15:8] <= reg_wdata_i;
         if (reg_wr_i && reg_addr_i == `ADDR_CCR) begin
            if (reg_wdata_i[`CCR_WRITE_SEEN]) write_seen_reg <= 1'b0;
            if (reg_wdata_i[`CCR_READ_SEEN]) read_seen_reg <= 1'b0;
         end
         if (ric_reg[`RIC_RUN_BIT]) begin
            running_reg <= 1'b1;
         end else if (instr_done_i) begin
            running_reg <= 1'b0;
         end
         if (instr_done_i && (running_reg || step_reg)) begin
            pc_reg <= pc_reg + 16'h0001;
            if (!running_reg) begin
               step_reg <= 1'b0;
            end
         end
         if (state_reg == TERM_STATE) begin
            if (target_reg == `TGT_DATA_MEMORY) begin
               read_seen_reg <= 1'b1;
            end
            if (instruction_memory_target) begin
               upper_byte_flag_reg <= ~upper_byte_flag_reg;
               if (target_reg == `TGT_INSTRUCTION_MEMORY_HI) begin
                  pc_reg <= pc_reg + 16'h0001;
               end
            end
         end
      end
   end

   // Read data and status outputs
   always @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o   <= 8'h00;
         cpu_running_o <= 1'b0;
         pc_o          <= `PC_RESET;
      end else begin
         cpu_running_o <= running_reg | step_reg;
         pc_o          <= pc_reg;
         reg_rdata_o   <= 8'h00;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `ADDR_RIC:   reg_rdata_o <= ric_reg & ~(8'h01 << `RIC_STEP_BIT);
               `ADDR_CCR:   reg_rdata_o <= {1'b0, write_seen_reg, read_seen_reg, 5'h00};
               `ADDR_DCR:   reg_rdata_o <= dcr_reg;
               `ADDR_PC_LO: reg_rdata_o <= pc_reg[7:0];
               `ADDR_PC_HI: reg_rdata_o <= pc_reg[15:8];
               default:     reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end

endmodule // remote_host_access_arbiter

// ---- remote_host_access_arbiter_monitor.sv ----
module arbiter_checker (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic remote_read_strobe_n_i,
   input wire logic local_bus_grant_o,
   input wire logic transfer_ack_pin_o,
   input wire logic bus_handover_pin_o,
   input wire logic mem_read_n_o,
   input wire logic addr_hi_oe_n_o,
   input wire logic ad_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Handshake and bus ownership during a remote read
   handover_ack_low_a: assert property ($rose(bus_handover_pin_o) |-> !transfer_ack_pin_o)
      else $error("Acknowledge high on handover");
   addr_float_a: assert property (bus_handover_pin_o |-> addr_hi_oe_n_o)
      else $error("Upper bus driven while host owns it");
   data_memory_float_a: assert property (!mem_read_n_o |-> addr_hi_oe_n_o && ad_oe_n_o && bus_handover_pin_o)
      else $error("Buses driven during data memory read");
   remote_no_grant_a: assert property (bus_handover_pin_o |-> !local_bus_grant_o)
      else $error("Local grant during remote access");
   valid_hold_a: assert property (bus_handover_pin_o && transfer_ack_pin_o && !remote_read_strobe_n_i
      |=> bus_handover_pin_o)
      else $error("Read closed while strobe still low");
   ack_rise_valid_a: assert property ($rose(transfer_ack_pin_o) |-> bus_handover_pin_o)
      else $error("Acknowledge rose outside data valid");
   ack_bound_a: assert property ($rose(bus_handover_pin_o) |-> ##[2:40] transfer_ack_pin_o)
      else $error("Data valid late");
   term_ack_a: assert property ($fell(bus_handover_pin_o) |-> transfer_ack_pin_o)
      else $error("Handover ended with acknowledge low");
   release_ack_a: assert property ($rose(addr_hi_oe_n_o) |-> !transfer_ack_pin_o)
      else $error("Bus released with acknowledge high");

   // Main scenarios reached
   cover property ($rose(bus_handover_pin_o));
   cover property (!mem_read_n_o);
   cover property (bus_handover_pin_o && !ad_oe_n_o);
endmodule // arbiter_checker

bind remote_host_access_arbiter arbiter_checker u_checker (.*);

// ---- remote_host_model.sv ----
module remote_host_model (
   input  wire logic       core_clk_i,
   input  wire logic       ack_i,
   input  wire logic       handover_i,
   input  wire logic [7:0] ad_i,
   output logic            rd_n_o,
   output logic            enable_o,
   output logic            select_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle host: strobe released high, enable off
   initial begin
      rd_n_o = 1'b1;
      enable_o = 1'b0;
      select_o = 1'b0;
   end

   task automatic strap(input logic low);
      rd_n_o <= ~low;
   endtask

   task automatic read(input logic sel, output logic [7:0] data, output int cyc);
      int n;
      cyc = 0;
      n = 0;
      @(posedge core_clk_i);
      rd_n_o <= 1'b0;
      enable_o <= 1'b1;
      select_o <= sel;
      while (!(handover_i && ack_i) && n < 400) begin
         @(negedge core_clk_i);
         cyc += int'(handover_i && !ack_i);
         n++;
      end
      data = ad_i;
      @(posedge core_clk_i);
      rd_n_o <= 1'b1;
      enable_o <= 1'b0;
      select_o <= ~sel;
      n = 0;
      while ((handover_i || n < 3) && n < 60) begin
         @(negedge core_clk_i);
         n++;
      end
   endtask
endmodule // remote_host_model

// ---- tb_remote_host_access_arbiter.sv ----
module tb_remote_host_access_arbiter;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, remote_read_strobe_n_i;
   logic        remote_write_strobe_n_i, remote_access_enable_i, reg_select_i, access_stretch_n_i;
   logic        local_block_n_i, local_bus_request_i, instr_start_i, instr_done_i;
   logic        local_bus_grant_o, timing_unit_stall_o, transfer_ack_pin_o, bus_handover_pin_o;
   logic        mem_read_n_o, addr_hi_oe_n_o, ad_oe_n_o, cpu_running_o;
   logic [3:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i, reg_rdata_o, data_addr_hi_i, addr_hi_o, ad_o, d;
   logic [15:0] instr_data_i, pc_o;
   int          seed, bad_count, checked, cycles, pc, remote_interface_config, dw, iw, k, ec, c;
   int          exp_q[$];
   int          msel_t[7] = '{0, 2, 3, 0, 1, 1, 1};

   remote_host_access_arbiter DUT (.*);
   remote_host_model host (.core_clk_i, .ack_i(transfer_ack_pin_o), .handover_i(bus_handover_pin_o),
      .ad_i(ad_o), .rd_n_o(remote_read_strobe_n_i), .enable_o(remote_access_enable_i), .select_o(reg_select_i));

   // Clock and hang guard
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   // Register port cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk("register read", {8'h00, e}, {8'h00, reg_rdata_o});
   endtask

   // One-cycle pulse to the timing unit inputs
   task automatic tick(input logic s);
      @(posedge core_clk_i);
      instr_start_i <= s;
      instr_done_i <= ~s;
      @(posedge core_clk_i);
      instr_start_i <= 1'b0;
      instr_done_i <= 1'b0;
      repeat (2) @(negedge core_clk_i);
   endtask

   // Remote read against the model queue
   task automatic rread(input logic sel, input int e, input logic cd);
      logic [7:0] got;
      int cyc;
      int eb;
      eb = exp_q.pop_front();
      host.read(sel, got, cyc);
      // Let termination finish before the caller looks at PC and flags
      repeat (2) @(negedge core_clk_i);
      if (cd) chk("read byte", 16'(eb), {8'h00, got});
      chk("wait cycles", 16'(e), 16'(cyc));
   endtask

   initial begin
      seed = 95419;
      sys_rst_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00;
      remote_write_strobe_n_i = 1'b1;
      access_stretch_n_i = 1'b1;
      local_block_n_i = 1'b1;
      local_bus_request_i = 1'b0;
      instr_start_i = 1'b0;
      instr_done_i = 1'b0;
      data_addr_hi_i = 8'h00;
      instr_data_i = 16'h0000;
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      data_addr_hi_i <= 8'($random(seed));
      instr_data_i <= 16'($random(seed));
      repeat (3) @(negedge core_clk_i);
      chk("running", 0, cpu_running_o);
      chk("upper bus", {8'h00, data_addr_hi_i}, {8'h00, addr_hi_o});
      chk("ad bus", 0, {8'h00, ad_o});
      chk("bus enables", 0, {addr_hi_oe_n_o, ad_oe_n_o});
      rd(4'hF, 8'h00);
      $display("Idle test done");
      // Every access target in turn
      pc = $random(seed) & 32'h0000_FFFF;
      dw = $random(seed) & 7;
      iw = $random(seed) & 3;
      remote_interface_config = $random(seed) & 32'h0000_00E0;
      wr(4'h3, 8'(pc));
      wr(4'h4, 8'(pc >> 8));
      wr(4'h2, 8'(dw * 4 + iw));
      for (k = 0; k < 7; k++) begin
         if (k != 6) wr(4'h0, 8'(remote_interface_config + msel_t[k] * 8));
         case (k)
            0: exp_q.push_back(remote_interface_config);
            1: exp_q.push_back(pc & 255);
            2: exp_q.push_back(pc >> 8);
            6: exp_q.push_back(int'(instr_data_i[15:8]));
            default: exp_q.push_back(int'(instr_data_i[7:0]));
         endcase
         ec = (k == 3) ? 2 + dw : ((k > 3) ? 2 + iw : 2);
         rread(k == 0, ec, k != 3);
         if (k == 6) pc = (pc + 1) & 32'h0000_FFFF;
         chk("pc", 16'(pc), pc_o);
         rd(4'h1, (k < 3) ? 8'h00 : 8'h20);
      end
      wr(4'h1, 8'h20);
      rd(4'h1, 8'h00);
      $display("Target test done");
      // Stretch pin held low past the programmed waits
      wr(4'h0, 8'(remote_interface_config));
      fork
         host.read(1'b0, d, c);
         begin
            @(posedge core_clk_i);
            access_stretch_n_i <= 1'b0;
            repeat (30) @(posedge core_clk_i);
            access_stretch_n_i <= 1'b1;
         end
      join
      chk("stretched", 1, 16'(c > 2 + dw));
      $display("Stretch test done");
      // Lockout holds the host off
      wr(4'h0, 8'h14);
      exp_q.push_back(pc & 255);
      fork
         rread(1'b0, 2, 1'b1);
         begin
            repeat (20) @(negedge core_clk_i);
            chk("held ack", 0, transfer_ack_pin_o);
            chk("held handover", 0, bus_handover_pin_o);
            wr(4'h0, 8'h10);
         end
      join
      @(negedge core_clk_i);
      chk("ad bus", 16'h0010, {8'h00, ad_o});
      $display("Lockout test done");
      // Block pin stalls, then a local grant delays the host
      @(posedge core_clk_i);
      local_block_n_i <= 1'b0;
      local_bus_request_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      tick(1'b1);
      chk("stall", 1, timing_unit_stall_o);
      @(posedge core_clk_i);
      local_block_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      tick(1'b1);
      chk("stall", 0, timing_unit_stall_o);
      chk("grant", 1, local_bus_grant_o);
      exp_q.push_back(pc & 255);
      fork
         rread(1'b0, 2, 1'b1);
         begin
            repeat (10) @(negedge core_clk_i);
            chk("granted ack", 0, transfer_ack_pin_o);
            chk("granted handover", 0, bus_handover_pin_o);
            @(posedge core_clk_i);
            local_bus_request_i <= 1'b0;
         end
      join
      $display("Local test done");
      // Single step, then run and stop
      wr(4'h0, 8'h02);
      tick(1'b1);
      tick(1'b0);
      pc = (pc + 1) & 32'h0000_FFFF;
      chk("step pc", 16'(pc), pc_o);
      chk("step idle", 0, cpu_running_o);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h01);
      repeat (3) @(negedge core_clk_i);
      chk("run", 1, cpu_running_o);
      chk("run pc", 16'(pc), pc_o);
      tick(1'b1);
      wr(4'h0, 8'h00);
      @(negedge core_clk_i);
      chk("finishing", 1, cpu_running_o);
      tick(1'b0);
      chk("halted", 0, cpu_running_o);
      $display("Execution test done");
      // both host strobes low across reset
      @(posedge core_clk_i);
      host.strap(1'b1);
      remote_write_strobe_n_i <= 1'b0;
      sys_rst_i <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(negedge core_clk_i);
      chk("strap run", 1, cpu_running_o);
      chk("strap pc", 0, pc_o);
      @(posedge core_clk_i);
      host.strap(1'b0);
      remote_write_strobe_n_i <= 1'b1;
      $display("Strap test done");
      summarize();
   end
endmodule // tb_remote_host_access_arbiter
